// ==== verilog/sbl_boot_loader.v ====
`timescale 1ns/1ps
`include "sbl_boot_loader_regs.vh"

// Functional notes
// - Two-wire master polls engine completion, no interrupts
// - Two-wire bit clock is peripheral clock over 128
// - Two-wire memory addressed at 0xa0
// - Two-wire keeps multiplier bypassed, peripheral clock halved
// - Two-wire bit rate stays at most 400 kbps
// - Four-wire port always driven as master
// - Identify first; blank answer means slow EEPROM
// - Other identification answers use fast Flash sequences
// - Main pins allow multiplier, alternate pins never
// - Four-wire boot errors raise event output three
// - Boot mode captured at power-on reset release
// - Multiplier bypassed until software enables it
// - Decode 0001, 10xx and 1100 boot modes
module sbl_boot_loader (
  input  wire        mclk_i,
  input  wire        rst_b_i,
  input  wire [3:0]  boot_mode_pins_i,
  input  wire [15:0] image_bytes_i,
  input  wire        pll_enable_i,
  input  wire        scl_i,
  output wire        scl_o,
  output wire        scl_oe_b_o,
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oe_b_o,
  output wire        spi_sck_o,
  output wire        spi_mosi_o,
  input  wire        spi_miso_i,
  output wire        spi_cs_b_o,
  output wire        alt_pin_set_o,
  output wire        pll_bypass_o,
  output wire        flash_mode_o,
  output wire        boot_busy_o,
  output wire        boot_done_o,
  output wire        boot_error_o,
  output wire        event_output_three_o,
  output wire [7:0]  data_o,
  output wire        data_valid_o,
  input  wire        data_ready_i
);
  localparam [2:0] ST_CAPTURE = 3'h0;
  localparam [2:0] ST_DECODE  = 3'h1;
  localparam [2:0] ST_ISSUE   = 3'h2;
  localparam [2:0] ST_WAIT    = 3'h3;
  localparam [2:0] ST_DONE    = 3'h4;
  localparam [2:0] ST_ERR     = 3'h5;

  localparam integer TW_BIT_I  = `SBL_TW_BIT_CYC;
  localparam integer TW_QTR_I  = `SBL_TW_QTR_CYC;
  localparam integer EE_HALF_I = `SBL_EE_HALF_CYC;
  localparam integer FL_HALF_I = `SBL_FL_HALF_CYC;
  // 256-cycle slot: low byte wraps to 255 on purpose
  localparam [7:0] TW_LAST  = TW_BIT_I[7:0] - 8'h01;
  localparam [7:0] TW_Q1    = TW_QTR_I[7:0];
  localparam [7:0] TW_Q2    = {TW_QTR_I[6:0], 1'b0};
  localparam [7:0] TW_Q3    = TW_Q1 + TW_Q2;
  localparam [7:0] EE_HALF  = EE_HALF_I[7:0];
  localparam [7:0] FL_HALF  = FL_HALF_I[7:0];

  // Sequence table: operation and byte for each step
  function [9:0] seq_op;
    input       spi;
    input [3:0] step;
    begin
      if (!spi)
        case (step)
          4'h0:    seq_op = {`SBL_OP_START, 8'h00};
          4'h1:    seq_op = {`SBL_OP_WR, `SBL_TW_ADDR_WR};
          4'h2:    seq_op = {`SBL_OP_WR, `SBL_ADDR_ZERO};
          4'h3:    seq_op = {`SBL_OP_WR, `SBL_ADDR_ZERO};
          4'h4:    seq_op = {`SBL_OP_START, 8'h00};
          4'h5:    seq_op = {`SBL_OP_WR, `SBL_TW_ADDR_RD};
          4'h6:    seq_op = {`SBL_OP_RD, 8'h00};
          default: seq_op = {`SBL_OP_STOP, 8'h00};
        endcase
      else
        case (step)
          4'h0:    seq_op = {`SBL_OP_START, 8'h00};
          4'h1:    seq_op = {`SBL_OP_WR, `SBL_CMD_ID};
          4'h2:    seq_op = {`SBL_OP_RD, 8'h00};
          4'h3:    seq_op = {`SBL_OP_STOP, 8'h00};
          4'h4:    seq_op = {`SBL_OP_START, 8'h00};
          4'h5:    seq_op = {`SBL_OP_WR, `SBL_CMD_READ};
          4'h6:    seq_op = {`SBL_OP_WR, `SBL_ADDR_ZERO};
          4'h7:    seq_op = {`SBL_OP_WR, `SBL_ADDR_ZERO};
          4'h8:    seq_op = {`SBL_OP_WR, `SBL_ADDR_ZERO};
          4'h9:    seq_op = {`SBL_OP_RD, 8'h00};
          default: seq_op = {`SBL_OP_STOP, 8'h00};
        endcase
    end
  endfunction

  function is_data_step;
    input       spi;
    input [3:0] step;
    begin
      is_data_step = spi ? (step == `SBL_SPI_STEP_DATA) :
                           (step == `SBL_TW_STEP_DATA);
    end
  endfunction

  reg  [2:0]  state_reg;
  reg  [3:0]  mode_reg;
  reg  [3:0]  step_reg;
  reg         spi_reg;
  reg         alt_reg;
  reg         ee_reg;
  reg         id_done_reg;
  reg  [16:0] cnt_reg;
  reg         go_reg;
  reg  [1:0]  op_kind_reg;
  reg  [7:0]  op_byte_reg;
  reg         op_ack_reg;
  reg         push_reg;
  reg         pll_bypass_reg;

  reg         busy_reg;
  reg         done_reg;
  reg         nack_reg;
  reg  [7:0]  phase_reg;
  reg  [3:0]  bit_reg;
  reg  [7:0]  tx_reg;
  reg  [7:0]  rx_reg;
  reg         scl_rel_reg;
  reg         sda_rel_reg;
  reg         sck_reg;
  reg         cs_b_reg;
  reg         scl_rel_next;
  reg         sda_rel_next;
  reg         sck_next;
  reg         cs_b_next;

  wire        fifo_in_ready;
  wire [9:0]  cur_op;
  wire [7:0]  half;
  wire [7:0]  slot_last;
  wire [7:0]  sample_at;
  wire [3:0]  last_bit;
  wire        slot_end;
  wire        last_byte;

  assign cur_op    = seq_op(spi_reg, step_reg);
  // Slow rate until the memory is identified as Flash
  assign half      = ee_reg ? EE_HALF : FL_HALF;
  assign slot_last = spi_reg ? ({half[6:0], 1'b0} - 8'h01) :
                               TW_LAST;
  assign sample_at = spi_reg ? half : TW_Q3;
  assign last_bit  = (op_kind_reg == `SBL_OP_START ||
                      op_kind_reg == `SBL_OP_STOP) ? 4'h0 :
                     (spi_reg ? 4'h7 : 4'h8);
  assign slot_end  = (phase_reg == slot_last);
  assign last_byte = (cnt_reg == {1'b0, image_bytes_i});

  // Mode capture, decode and step sequencing
  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg   <= ST_CAPTURE;
      mode_reg    <= 4'h0;
      step_reg    <= 4'h0;
      spi_reg     <= 1'b0;
      alt_reg     <= 1'b0;
      ee_reg      <= 1'b1;
      id_done_reg <= 1'b0;
      cnt_reg     <= 17'h00000;
      go_reg      <= 1'b0;
      op_kind_reg <= `SBL_OP_START;
      op_byte_reg <= 8'h00;
      op_ack_reg  <= 1'b0;
      push_reg    <= 1'b0;
    end
    else
    begin
      go_reg   <= 1'b0;
      push_reg <= 1'b0;
      case (state_reg)
        ST_CAPTURE:
        begin
          // Pins are taken at the first edge after release
          mode_reg  <= boot_mode_pins_i;
          state_reg <= ST_DECODE;
        end
        ST_DECODE:
        begin
          if (mode_reg == `SBL_MODE_TW)
          begin
            spi_reg   <= 1'b0;
            state_reg <= ST_ISSUE;
          end
          else if (mode_reg[3:2] == `SBL_MODE_MAIN_HI)
          begin
            spi_reg   <= 1'b1;
            state_reg <= ST_ISSUE;
          end
          else if (mode_reg == `SBL_MODE_ALT)
          begin
            spi_reg   <= 1'b1;
            alt_reg   <= 1'b1;
            state_reg <= ST_ISSUE;
          end
          else
            state_reg <= ST_ERR;
        end
        ST_ISSUE:
        begin
          // Pending push not yet counted; wait so no byte is dropped
          if (!is_data_step(spi_reg, step_reg) ||
              (fifo_in_ready && !push_reg))
          begin
            go_reg      <= 1'b1;
            op_kind_reg <= cur_op[9:8];
            op_byte_reg <= cur_op[7:0];
            op_ack_reg  <= ~last_byte;
            state_reg   <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (done_reg)
          begin
            if (!spi_reg && op_kind_reg == `SBL_OP_WR && nack_reg)
              state_reg <= ST_ERR;
            else if (is_data_step(spi_reg, step_reg))
            begin
              if (cnt_reg == 17'h00000 && rx_reg != `SBL_MARKER)
                state_reg <= ST_ERR;
              else
              begin
                push_reg  <= (cnt_reg != 17'h00000);
                cnt_reg   <= cnt_reg + 17'h00001;
                state_reg <= ST_ISSUE;
                if (last_byte)
                  step_reg <= step_reg + 4'h1;
              end
            end
            else if ((spi_reg && step_reg == `SBL_SPI_STEP_STOP) ||
                     (!spi_reg && step_reg == `SBL_TW_STEP_STOP))
              state_reg <= ST_DONE;
            else
            begin
              if (spi_reg && step_reg == `SBL_SPI_STEP_ID)
              begin
                ee_reg      <= (rx_reg == `SBL_ID_BLANK_LO) ||
                               (rx_reg == `SBL_ID_BLANK_HI);
                id_done_reg <= 1'b1;
              end
              // EEPROM takes a two-byte address, Flash three
              if (spi_reg && ee_reg && step_reg == `SBL_SPI_STEP_A1)
                step_reg <= `SBL_SPI_STEP_DATA;
              else
                step_reg <= step_reg + 4'h1;
              state_reg <= ST_ISSUE;
            end
          end
        end
        ST_DONE:
          state_reg <= ST_DONE;
        ST_ERR:
          state_reg <= ST_ERR;
        default:
          state_reg <= ST_ERR;
      endcase
    end
  end

  // Pin levels for the current bit slot
  always @*
  begin
    scl_rel_next = scl_rel_reg;
    sda_rel_next = sda_rel_reg;
    sck_next     = sck_reg;
    cs_b_next    = cs_b_reg;
    if (state_reg == ST_ERR)
    begin
      // Free the bus so the memory is not left mid-transfer
      scl_rel_next = 1'b1;
      sda_rel_next = 1'b1;
      sck_next     = 1'b0;
      cs_b_next    = 1'b1;
    end
    else if (busy_reg && !spi_reg)
      case (op_kind_reg)
        `SBL_OP_START:
        begin
          scl_rel_next = (phase_reg >= TW_Q1) && (phase_reg < TW_Q3);
          sda_rel_next = (phase_reg < TW_Q2);
        end
        `SBL_OP_STOP:
        begin
          scl_rel_next = (phase_reg >= TW_Q1);
          sda_rel_next = (phase_reg >= TW_Q2);
        end
        `SBL_OP_WR:
        begin
          scl_rel_next = (phase_reg >= TW_Q2);
          sda_rel_next = (bit_reg == 4'h8) ? 1'b1 : tx_reg[7];
        end
        default:
        begin
          scl_rel_next = (phase_reg >= TW_Q2);
          sda_rel_next = (bit_reg == 4'h8) ? ~op_ack_reg : 1'b1;
        end
      endcase
    else if (busy_reg)
      case (op_kind_reg)
        `SBL_OP_START:
        begin
          cs_b_next = 1'b0;
          sck_next  = 1'b0;
        end
        `SBL_OP_STOP:
        begin
          cs_b_next = 1'b1;
          sck_next  = 1'b0;
        end
        // Falls with the slot end so mosi only moves while sck is low
        default:
          sck_next = (phase_reg >= half - 8'h01) && !slot_end;
      endcase
  end

  // Bit engine; completion is a flag the sequencer polls
  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      busy_reg    <= 1'b0;
      done_reg    <= 1'b0;
      nack_reg    <= 1'b0;
      phase_reg   <= 8'h00;
      bit_reg     <= 4'h0;
      tx_reg      <= 8'h00;
      rx_reg      <= 8'h00;
      scl_rel_reg <= 1'b1;
      sda_rel_reg <= 1'b1;
      sck_reg     <= 1'b0;
      cs_b_reg    <= 1'b1;
    end
    else
    begin
      done_reg    <= 1'b0;
      scl_rel_reg <= scl_rel_next;
      sda_rel_reg <= sda_rel_next;
      sck_reg     <= sck_next;
      cs_b_reg    <= cs_b_next;
      if (go_reg && !busy_reg)
      begin
        busy_reg  <= 1'b1;
        phase_reg <= 8'h00;
        bit_reg   <= 4'h0;
        tx_reg    <= op_byte_reg;
        nack_reg  <= 1'b0;
      end
      else if (busy_reg)
      begin
        if (phase_reg == sample_at && bit_reg < 4'h8)
          rx_reg <= {rx_reg[6:0], spi_reg ? spi_miso_i : sda_i};
        if (phase_reg == sample_at && bit_reg == 4'h8)
          nack_reg <= sda_i;
        if (slot_end)
        begin
          phase_reg <= 8'h00;
          tx_reg    <= {tx_reg[6:0], 1'b0};
          bit_reg   <= bit_reg + 4'h1;
          if (bit_reg == last_bit)
          begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
          end
        end
        else
          phase_reg <= phase_reg + 8'h01;
      end
    end
  end

  // Multiplier stays bypassed unless main four-wire pins are in use
  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      pll_bypass_reg <= 1'b1;
    else
      pll_bypass_reg <= ~(pll_enable_i && spi_reg && !alt_reg &&
                          state_reg != ST_CAPTURE &&
                          state_reg != ST_DECODE);
  end

  sbl_fifo #(
    .WIDTH (8),
    .DEPTH (8),
    .AW    (3)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_b_i     (rst_b_i),
    .in_data_i   (rx_reg),
    .in_valid_i  (push_reg),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (data_o),
    .out_valid_o (data_valid_o),
    .out_ready_i (data_ready_i)
  );

  // Open-drain: drive low only, enable active low while driving
  assign scl_o                = 1'b0;
  assign sda_o                = 1'b0;
  assign scl_oe_b_o           = scl_rel_reg;
  assign sda_oe_b_o           = sda_rel_reg;
  assign spi_sck_o            = sck_reg;
  assign spi_mosi_o           = tx_reg[7];
  assign spi_cs_b_o           = cs_b_reg;
  assign alt_pin_set_o        = alt_reg;
  assign pll_bypass_o         = pll_bypass_reg;
  assign flash_mode_o         = spi_reg & id_done_reg & ~ee_reg;
  assign boot_busy_o          = (state_reg == ST_ISSUE) ||
                                (state_reg == ST_WAIT);
  assign boot_done_o          = (state_reg == ST_DONE);
  assign boot_error_o         = (state_reg == ST_ERR);
  assign event_output_three_o = (state_reg == ST_ERR) & spi_reg;
endmodule

// ==== verilog/sbl_boot_loader_regs.vh ====
`ifndef SBL_BOOT_LOADER_REGS_VH
`define SBL_BOOT_LOADER_REGS_VH

// Clock and rates in kHz and kbps, dividers, fast half period in cycles
`define SBL_MCLK_KHZ        50000
`define SBL_IN_CLK_MAX_KHZ  100000
`define SBL_PERIPH_DIV      2
`define SBL_TW_DIV          128
`define SBL_TW_MAX_KBPS     400
`define SBL_EE_MAX_KBPS     4000
`define SBL_FL_HALF_CYC     2

// Derived cycle counts
`define SBL_TW_BIT_CYC  (`SBL_PERIPH_DIV * `SBL_TW_DIV)
`define SBL_TW_QTR_CYC  (`SBL_TW_BIT_CYC / 4)
`define SBL_EE_HALF_CYC \
  ((`SBL_MCLK_KHZ + 2 * `SBL_EE_MAX_KBPS - 1) / (2 * `SBL_EE_MAX_KBPS))

// Two-wire addressing
`define SBL_TW_ADDR_WR  8'ha0
`define SBL_TW_ADDR_RD  8'ha1

// Four-wire commands and identification answers
`define SBL_CMD_ID        8'h9f
`define SBL_CMD_READ      8'h03
`define SBL_ID_BLANK_LO   8'h00
`define SBL_ID_BLANK_HI   8'hff
`define SBL_ADDR_ZERO     8'h00

// Boot mode codes
`define SBL_MODE_TW       4'h1
`define SBL_MODE_MAIN_HI  2'h2
`define SBL_MODE_ALT      4'hc

// Image header byte
`define SBL_MARKER        8'h5a

// Engine operations
`define SBL_OP_START  2'h0
`define SBL_OP_STOP   2'h1
`define SBL_OP_WR     2'h2
`define SBL_OP_RD     2'h3

// Step numbers
`define SBL_TW_STEP_DATA   4'h6
`define SBL_TW_STEP_STOP   4'h7
`define SBL_SPI_STEP_ID    4'h2
`define SBL_SPI_STEP_A1    4'h7
`define SBL_SPI_STEP_DATA  4'h9
`define SBL_SPI_STEP_STOP  4'ha

`endif

// ==== verilog/sbl_fifo.v ====
`timescale 1ns/1ps
module sbl_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
)(
  input  wire             mclk_i,
  input  wire             rst_b_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  reg [WIDTH-1:0] out_reg;
  reg             out_valid_reg;
  wire            push;
  wire            pull;

  assign in_ready_o  = (count_reg != DEPTH[AW:0]);
  assign push        = in_valid_i & in_ready_o;
  // Output stage refills when memory holds data and it is empty or being drained
  assign pull        = (count_reg != {(AW+1){1'b0}}) &
                       (~out_valid_reg | out_ready_i);
  assign out_data_o  = out_reg;
  assign out_valid_o = out_valid_reg;

  always @(posedge mclk_i)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data_i;
  end

  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_ptr_reg    <= {AW{1'b0}};
      rd_ptr_reg    <= {AW{1'b0}};
      count_reg     <= {(AW+1){1'b0}};
      out_reg       <= {WIDTH{1'b0}};
      out_valid_reg <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pull)
      begin
        out_reg       <= mem_reg[rd_ptr_reg];
        out_valid_reg <= 1'b1;
        rd_ptr_reg    <= rd_ptr_reg + 1'b1;
      end
      else if (out_ready_i)
        out_valid_reg <= 1'b0;
      if (push & ~pull)
        count_reg <= count_reg + 1'b1;
      else if (pull & ~push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule

// ==== verification/sbl_boot_loader_chk.sv ====
`timescale 1ns/1ps
module sbl_chk (
  input wire mclk_i,
  input wire rst_b_i,
  input wire pll_enable_i,
  input wire scl_oe_b_o,
  input wire sda_oe_b_o,
  input wire spi_sck_o,
  input wire spi_mosi_o,
  input wire spi_cs_b_o,
  input wire alt_pin_set_o,
  input wire pll_bypass_o,
  input wire flash_mode_o,
  input wire boot_done_o,
  input wire boot_error_o,
  input wire event_output_three_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  property p_mosi_hold;
    spi_sck_o && $past(spi_sck_o) |-> $stable(spi_mosi_o);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("mosi moved while sck high");
  property p_err_hold;
    boot_error_o |=> boot_error_o;
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("error flag dropped");
  property p_evt_hold;
    event_output_three_o |=> event_output_three_o && boot_error_o;
  endproperty
  a_evt_hold: assert property (p_evt_hold)
    else $error("event three dropped or without error");
  property p_err_quiet;
    boot_error_o && $past(boot_error_o, 4)
      |-> spi_cs_b_o && scl_oe_b_o && sda_oe_b_o && !spi_sck_o;
  endproperty
  a_err_quiet: assert property (p_err_quiet)
    else $error("bus active after error");
  property p_alt_byp;
    alt_pin_set_o |-> pll_bypass_o;
  endproperty
  a_alt_byp: assert property (p_alt_byp)
    else $error("multiplier on with alternate pins");
  property p_tw_byp;
    (!scl_oe_b_o || !sda_oe_b_o) |-> pll_bypass_o;
  endproperty
  a_tw_byp: assert property (p_tw_byp)
    else $error("multiplier on during two-wire boot");
  property p_req_byp;
    !pll_enable_i && !$past(pll_enable_i) |-> pll_bypass_o;
  endproperty
  a_req_byp: assert property (p_req_byp)
    else $error("multiplier on without request");
  property p_ee_rate;
    $rose(spi_sck_o) && !flash_mode_o |-> spi_sck_o [*7] ##1 !spi_sck_o;
  endproperty
  a_ee_rate: assert property (p_ee_rate)
    else $error("slow sck high phase not 7 cycles");
  property p_fl_rate;
    $rose(spi_sck_o) && flash_mode_o && $past(flash_mode_o, 16)
      |-> spi_sck_o [*2] ##1 !spi_sck_o;
  endproperty
  a_fl_rate: assert property (p_fl_rate)
    else $error("fast sck high phase not 2 cycles");
  c_flash: cover property (flash_mode_o && boot_done_o);
  c_evt: cover property (event_output_three_o);
  c_tw: cover property (!scl_oe_b_o);
endmodule
bind sbl_boot_loader sbl_chk u_chk (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .pll_enable_i(pll_enable_i),
  .scl_oe_b_o(scl_oe_b_o), .sda_oe_b_o(sda_oe_b_o),
  .spi_sck_o(spi_sck_o), .spi_mosi_o(spi_mosi_o),
  .spi_cs_b_o(spi_cs_b_o), .alt_pin_set_o(alt_pin_set_o),
  .pll_bypass_o(pll_bypass_o), .flash_mode_o(flash_mode_o),
  .boot_done_o(boot_done_o), .boot_error_o(boot_error_o),
  .event_output_three_o(event_output_three_o));

// ==== verification/sbl_mem_model.sv ====
`timescale 1ns/1ps
module sbl_mem_model (
  input  wire       spi_sck_i,
  input  wire       spi_mosi_i,
  input  wire       spi_cs_b_i,
  input  wire [7:0] id_i,
  input  wire [7:0] hdr_i,
  output reg        spi_miso_o
);
  reg [7:0] shift_reg;
  reg [7:0] out_reg;
  reg [7:0] cmd_reg;
  reg [7:0] nbyte;
  reg [7:0] alen;
  reg [3:0] bits;
  initial spi_miso_o = 1'b0;
  always @(negedge spi_cs_b_i)
  begin
    bits = 4'h0;
    nbyte = 8'h00;
    cmd_reg = 8'h00;
  end
  // Slave only: moves solely on the master's clock and chip select
  always @(posedge spi_sck_i)
    if (!spi_cs_b_i)
    begin
      shift_reg = {shift_reg[6:0], spi_mosi_i};
      bits = bits + 4'h1;
      if (bits == 4'h8)
      begin
        if (nbyte == 8'h00)
          cmd_reg = shift_reg;
        bits = 4'h0;
        nbyte = nbyte + 8'h01;
      end
    end
  // Blank answer means two address bytes, else three
  always @(negedge spi_sck_i)
    if (!spi_cs_b_i)
    begin
      alen = (id_i == 8'h00 || id_i == 8'hff) ? 8'h02 : 8'h03;
      if (bits != 4'h0)
        out_reg = {out_reg[6:0], 1'b0};
      else if (cmd_reg == 8'h9f)
        out_reg = id_i;
      else if (cmd_reg == 8'h03 && nbyte == alen + 8'h01)
        out_reg = hdr_i;
      else if (cmd_reg == 8'h03 && nbyte > alen + 8'h01)
        out_reg = 8'h30 + nbyte - alen - 8'h01;
      else
        out_reg = 8'h00;
      spi_miso_o = out_reg[7];
    end
  // Deselected line must not look like a held bit
  always @(posedge spi_cs_b_i)
    spi_miso_o = ~spi_miso_o;
endmodule

// ==== verification/sbl_boot_loader_bench.sv ====
`timescale 1ns/1ps
module sbl_boot_loader_bench;
  reg         mclk_i;
  reg         rst_b_i;
  reg  [3:0]  mode;
  reg  [15:0] nbytes;
  reg         pll_en;
  reg         ready;
  reg  [7:0]  id_byte;
  reg  [7:0]  hdr_byte;
  reg  [7:0]  addr;
  wire        scl_o, scl_oe_b_o, sda_o, sda_oe_b_o, scl_i, sda_i;
  wire        spi_sck_o, spi_mosi_o, spi_cs_b_o, miso;
  wire        alt_pin_set_o, pll_bypass_o, flash_mode_o;
  wire        boot_busy_o, boot_done_o, boot_error_o;
  wire        event_output_three_o, data_valid_o;
  wire [7:0]  data_o;
  integer     failures, compares, guard, ticks, k, tk0;
  // Pull-ups on both two-wire lines; no slave answers, so it NACKs
  assign scl_i = scl_oe_b_o ? 1'b1 : scl_o;
  assign sda_i = sda_oe_b_o ? 1'b1 : sda_o;
  sbl_boot_loader dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .boot_mode_pins_i(mode),
    .image_bytes_i(nbytes), .pll_enable_i(pll_en),
    .scl_i(scl_i), .scl_o(scl_o), .scl_oe_b_o(scl_oe_b_o),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_b_o(sda_oe_b_o),
    .spi_sck_o(spi_sck_o), .spi_mosi_o(spi_mosi_o), .spi_miso_i(miso),
    .spi_cs_b_o(spi_cs_b_o), .alt_pin_set_o(alt_pin_set_o),
    .pll_bypass_o(pll_bypass_o), .flash_mode_o(flash_mode_o),
    .boot_busy_o(boot_busy_o), .boot_done_o(boot_done_o),
    .boot_error_o(boot_error_o),
    .event_output_three_o(event_output_three_o),
    .data_o(data_o), .data_valid_o(data_valid_o), .data_ready_i(ready));
  sbl_mem_model u_mem (
    .spi_sck_i(spi_sck_o), .spi_mosi_i(spi_mosi_o),
    .spi_cs_b_i(spi_cs_b_o), .id_i(id_byte), .hdr_i(hdr_byte),
    .spi_miso_o(miso));
  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  task finish_test;
  begin
    $display("Compares %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  end
  endtask
  // One shared budget bounds every wait in the run
  task tick;
  begin
    @(negedge mclk_i);
    ticks = ticks + 1;
    guard = guard + 1;
    if (guard > 90000)
    begin
      failures = failures + 1;
      $display("FAIL %0t wait limit used up", $time);
      finish_test;
    end
  end
  endtask
  task boot(input [3:0] m, input [7:0] id, input [7:0] hdr, input p);
  begin
    @(negedge mclk_i);
    rst_b_i = 1'b0;
    mode = m;
    id_byte = id;
    hdr_byte = hdr;
    pll_en = p;
    ready = 1'b0;
    repeat (6) @(negedge mclk_i);
    rst_b_i = 1'b1;
  end
  endtask
  task take(input [7:0] exp);
  begin
    while (data_valid_o !== 1'b1)
    begin
      ready = 1'b0;
      tick;
    end
    chk(data_o, exp);
    ready = 1'b1;
    @(negedge mclk_i);
  end
  endtask
  // Sink stalls until the buffer refuses, then drains all 12 bytes
  task run_ok(input [3:0] m, input [7:0] id, input p,
              input ef, input eb, input ea);
  begin
    boot(m, id, 8'h5a, p);
    tick;
    tick;
    mode = ~m; // Pins move once captured
    k = 0;
    while (k < 300)
    begin
      tick;
      k = (spi_sck_o === 1'b0) ? k + 1 : 0;
    end
    chk({boot_busy_o, boot_done_o, data_valid_o}, 16'h5);
    for (k = 1; k <= 12; k = k + 1)
      take(8'h30 + k);
    while (boot_done_o !== 1'b1 && boot_error_o !== 1'b1)
      tick;
    chk({boot_error_o, event_output_three_o}, 16'h0);
    chk(flash_mode_o, ef);
    chk(pll_bypass_o, eb);
    chk(alt_pin_set_o, ea);
    chk(scl_oe_b_o & sda_oe_b_o, 1'b1);
  end
  endtask
  initial
  begin
    rst_b_i = 1'b0;
    mode = 4'h0;
    nbytes = 16'd12;
    pll_en = 1'b0;
    ready = 1'b0;
    id_byte = 8'hff;
    hdr_byte = 8'h5a;
    addr = 8'h00;
    failures = 0;
    compares = 0;
    guard = 0;
    ticks = 0;
    tk0 = 0;
    run_ok(4'h8, 8'hff, 1'b0, 1'b0, 1'b1, 1'b0);
    run_ok(4'ha, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0);
    run_ok(4'hb, 8'hc2, 1'b1, 1'b1, 1'b0, 1'b0);
    run_ok(4'hc, 8'hc2, 1'b1, 1'b1, 1'b1, 1'b1);
    boot(4'h9, 8'h47, 8'ha5, 1'b0);
    while (boot_error_o !== 1'b1)
      tick;
    repeat (200) tick;
    chk(event_output_three_o, 1'b1);
    chk({boot_error_o, data_valid_o, spi_cs_b_o}, 16'h5);
    boot(4'h3, 8'hff, 8'h5a, 1'b0);
    repeat (4) tick;
    chk({boot_error_o, spi_cs_b_o, scl_oe_b_o}, 16'h7);
    chk(event_output_three_o, 1'b0);
    boot(4'h1, 8'hff, 8'h5a, 1'b1);
    while (!(scl_i === 1'b1 && sda_i === 1'b0))
      tick;
    for (k = 0; k < 8; k = k + 1)
    begin
      while (scl_i !== 1'b0)
        tick;
      while (scl_i !== 1'b1)
        tick;
      addr = {addr[6:0], sda_i};
      if (k == 0)
        tk0 = ticks;
      if (k == 1)
        chk(ticks - tk0, 16'd256);
    end
    chk(addr, 8'ha0);
    chk(pll_bypass_o, 1'b1);
    while (boot_error_o !== 1'b1)
      tick;
    repeat (8) tick;
    chk(event_output_three_o, 1'b0);
    chk({scl_oe_b_o, sda_oe_b_o, boot_done_o}, 16'h6);
    finish_test;
  end
endmodule
